/* File: rtl/lvocr_pkg.sv */
// constants for the lvds output control register bank
package lvocr_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL   = 10'h204;
  localparam logic [9:0] IDX_PAT    = 10'h205;
  localparam logic [9:0] IDX_CSE    = 10'h206;
  localparam logic [9:0] IDX_STATUS = 10'h208;
  localparam logic [9:0] IDX_CFG    = 10'h20c;
  localparam logic [9:0] IDX_USER_PATTERN   = 10'h20d;
  localparam int         AW         = 12;
  // lvds_control fields
  localparam int CTRL_SCR    = 4;
  localparam int CTRL_SRC_LO = 2;
  localparam int CTRL_FMT    = 1;
  // pattern_select fields
  localparam int PAT_ACT_LO = 4;
  // link_status fields
  localparam int ST_LEVEL = 5;
  localparam int ST_REALN = 4;
  localparam int ST_ALN   = 3;
  // link_config fields
  localparam int CFG_EN    = 0;
  localparam int CFG_LANE  = 1;
  localparam int CFG_PD_LO = 2;
  localparam int CFG_TSRX  = 4;
  localparam int CFG_SWREQ = 5;
  localparam int CFG_ALM   = 8;
  // reset values
  localparam logic [7:0]  CTRL_RST = 8'h02;
  localparam logic [7:0]  PAT_RST  = 8'h02;
  localparam logic [7:0]  CSE_RST  = 8'hff;
  localparam logic [7:0]  CFG_RST  = 8'h22;
  localparam logic [11:0] USER_PATTERN_RST = 12'h000;
  localparam logic [14:0] LFSR_SEED = 15'h7fff;
  // request source codes
  typedef enum logic [1:0] {
    SRC_PIN  = 2'h0,
    SRC_TS   = 2'h1,
    SRC_NONE = 2'h2
  } lvocr_src_e;
  // pattern codes
  localparam logic [3:0] ACT_SAMPLES = 4'h0;
  localparam logic [3:0] ACT_USER    = 4'h1;
  localparam logic [3:0] ALN_USER    = 4'h1;
  localparam logic [3:0] ALN_LSB     = 4'h2;
  localparam logic [3:0] ALN_ALL     = 4'h3;
endpackage

/* File: rtl/lvocr_regs.sv */
// lvds output control registers, pattern mux and output gating
// What this block does
// - scramble bit scrambles all data and strobes
// - source field selects request, default pin
// - source 1 uses timestamp pair receiver
// - source 2 ignores all request pins
// - format bit: offset binary or twos complement
// - active pattern: samples or user pattern
// - alignment pattern code 1 sends user pattern
// - code 2 puts strobe on sample lsb
// - code 3 strobe on all lanes, strobes
// - per-output clock and strobe enables
// - unused bus loses clock and strobe
// - status shows live selected request level
// - realign event sets realigned flag
// - write one clears realigned, alarm kept
// - reference edge while enabled sets aligned
// - write one clears aligned until next edge
// - software request bit low always requests alignment
// - disabled interface: reset, bus outputs off, clocks off
// - lane mode: two or four buses
// - powered-down channel loses its buses
//
// The APB slave port was left to the implementer.
module lvocr_regs (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [lvocr_pkg::AW-1:0]  paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      align_request_pin,
  input  wire logic                      timestamp_input_pair,
  input  wire logic                      system_reference,
  input  wire logic                      clock_realign_event,
  input  wire logic                      frame_strobe,
  input  wire logic [47:0]               sample_in,
  output logic      [47:0]               bus_data,
  output logic      [3:0]                bus_frame_strobe,
  output logic      [3:0]                bus_data_clock,
  output logic                           align_request_active
);
  logic [7:0]  ctrl_ff;
  logic [7:0]  pat_ff;
  logic [7:0]  cse_ff;
  logic [5:0]  cfg_ff;
  logic        alarm_ff;
  logic [11:0] user_pattern_ff;
  logic        realigned_ff;
  logic        aligned_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic [2:0]  meta_ff;
  logic [2:0]  sync_ff;
  logic        sref_prev_ff;
  logic [14:0] lfsr_ff;
  logic        clk_tog_ff;
  logic [47:0] bus_data_ff;
  logic [3:0]  stb_ff;
  logic [3:0]  dclk_ff;
  logic        req_ff;
  logic [9:0]  idx;
  logic        hit;
  logic        access;
  logic        wr_ok;
  logic [31:0] rd_data;
  logic        sel_n;
  logic        align_active;
  logic        sref_rise;
  logic        iface_en;
  logic [3:0]  bus_used;
  wire  [47:0] nxt_bus_data;
  wire  [3:0]  nxt_stb;
  lvocr_pkg::lvocr_src_e src;

  // field views
  assign iface_en = cfg_ff[lvocr_pkg::CFG_EN];
  assign src      = lvocr_pkg::lvocr_src_e'(ctrl_ff[lvocr_pkg::CTRL_SRC_LO +: 2]);
  assign idx      = paddr[lvocr_pkg::AW-1:2];

  // apb decode
  always_comb begin
    hit = (paddr[1:0] == 2'h0) &&
          (idx == lvocr_pkg::IDX_CTRL || idx == lvocr_pkg::IDX_PAT ||
           idx == lvocr_pkg::IDX_CSE || idx == lvocr_pkg::IDX_STATUS ||
           idx == lvocr_pkg::IDX_CFG || idx == lvocr_pkg::IDX_USER_PATTERN);
    rd_data = 32'h0000_0000;
    case (idx)
      lvocr_pkg::IDX_CTRL:   rd_data[7:0] = ctrl_ff;
      lvocr_pkg::IDX_PAT:    rd_data[7:0] = pat_ff;
      lvocr_pkg::IDX_CSE:    rd_data[7:0] = cse_ff;
      lvocr_pkg::IDX_STATUS: rd_data[7:0] = {2'h0, sel_n, realigned_ff, aligned_ff, 3'h0};
      lvocr_pkg::IDX_CFG:    rd_data[8:0] = {alarm_ff, 2'h0, cfg_ff};
      lvocr_pkg::IDX_USER_PATTERN:   rd_data[11:0] = user_pattern_ff;
      default:               rd_data = 32'h0000_0000;
    endcase
  end

  assign access = psel & penable & ~pready_ff;
  assign wr_ok  = psel & penable & pready_ff & pwrite & ~pslverr_ff;

  // apb answer, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= access;
      pslverr_ff <= access & ~hit;
      prdata_ff  <= (access & ~pwrite & hit) ? rd_data : 32'h0000_0000;
    end
  end

  // software control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= lvocr_pkg::CTRL_RST;
      pat_ff  <= lvocr_pkg::PAT_RST;
      cse_ff  <= lvocr_pkg::CSE_RST;
      cfg_ff  <= lvocr_pkg::CFG_RST[5:0];
      user_pattern_ff <= lvocr_pkg::USER_PATTERN_RST;
    end else if (wr_ok) begin
      if (pstrb[0]) begin
        case (idx)
          lvocr_pkg::IDX_CTRL: ctrl_ff <= pwdata[7:0];
          lvocr_pkg::IDX_PAT:  pat_ff  <= pwdata[7:0];
          lvocr_pkg::IDX_CSE:  cse_ff  <= pwdata[7:0];
          lvocr_pkg::IDX_CFG:  cfg_ff  <= pwdata[5:0];
          lvocr_pkg::IDX_USER_PATTERN: user_pattern_ff[7:0] <= pwdata[7:0];
          default: ;
        endcase
      end
      if (pstrb[1] && idx == lvocr_pkg::IDX_USER_PATTERN) begin
        user_pattern_ff[11:8] <= pwdata[11:8];
      end
    end
  end

  // two-stage synchronisers for pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff      <= 3'h7;
      sync_ff      <= 3'h7;
      sref_prev_ff <= 1'b1;
    end else begin
      meta_ff      <= {system_reference, timestamp_input_pair, align_request_pin};
      sync_ff      <= meta_ff;
      sref_prev_ff <= sync_ff[2];
    end
  end
  assign sref_rise = sync_ff[2] & ~sref_prev_ff;

  // request source select and effective request
  always_comb begin
    case (src)
      lvocr_pkg::SRC_PIN:  sel_n = sync_ff[0];
      lvocr_pkg::SRC_TS:   sel_n = cfg_ff[lvocr_pkg::CFG_TSRX] ? sync_ff[1] : 1'b1;
      lvocr_pkg::SRC_NONE: sel_n = 1'b1;
      default:             sel_n = 1'b1;
    endcase
    align_active = ~sel_n | ~cfg_ff[lvocr_pkg::CFG_SWREQ];
  end

  // status flags, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      realigned_ff <= 1'b0;
      aligned_ff   <= 1'b0;
      alarm_ff     <= 1'b0;
    end else begin
      if (clock_realign_event) begin
        realigned_ff <= 1'b1;
      end else if (wr_ok && pstrb[0] && idx == lvocr_pkg::IDX_STATUS &&
                   pwdata[lvocr_pkg::ST_REALN]) begin
        realigned_ff <= 1'b0;
      end
      if (sref_rise && iface_en) begin
        aligned_ff <= 1'b1;
      end else if (wr_ok && pstrb[0] && idx == lvocr_pkg::IDX_STATUS &&
                   pwdata[lvocr_pkg::ST_ALN]) begin
        aligned_ff <= 1'b0;
      end
      if (clock_realign_event) begin
        alarm_ff <= 1'b1;
      end else if (wr_ok && pstrb[1] && idx == lvocr_pkg::IDX_CFG &&
                   pwdata[lvocr_pkg::CFG_ALM]) begin
        alarm_ff <= 1'b0;
      end
    end
  end

  // scrambler and clock toggle, held in reset while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_ff    <= lvocr_pkg::LFSR_SEED;
      clk_tog_ff <= 1'b0;
    end else if (!iface_en) begin
      lfsr_ff    <= lvocr_pkg::LFSR_SEED;
      clk_tog_ff <= 1'b0;
    end else begin
      lfsr_ff    <= {lfsr_ff[13:0], lfsr_ff[14] ^ lfsr_ff[13]};
      clk_tog_ff <= ~clk_tog_ff;
    end
  end

  // output word of one bus
  // every input is an argument so the continuous assign follows each of them
  function automatic logic [11:0] bus_word(input logic [11:0] raw,
                                           input logic [7:0]  ctl,
                                           input logic [7:0]  pat,
                                           input logic [11:0] user_pattern,
                                           input logic        aln,
                                           input logic        fstb,
                                           input logic [11:0] scr_bits);
    logic [11:0] act;
    logic [11:0] w;
    act = ctl[lvocr_pkg::CTRL_FMT] ? {~raw[11], raw[10:0]} : raw;
    if (pat[lvocr_pkg::PAT_ACT_LO +: 4] == lvocr_pkg::ACT_USER) begin
      act = user_pattern;
    end
    w = act;
    if (aln) begin
      case (pat[3:0])
        lvocr_pkg::ALN_USER: w = user_pattern;
        lvocr_pkg::ALN_LSB:  w = {act[11:1], fstb};
        lvocr_pkg::ALN_ALL:  w = {12{fstb}};
        default:             w = act;
      endcase
    end
    if (ctl[lvocr_pkg::CTRL_SCR]) begin
      w = w ^ scr_bits;
    end
    return w;
  endfunction

  // per-bus use, data and strobe
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_bus
      assign bus_used[gi] = iface_en & (cfg_ff[lvocr_pkg::CFG_LANE] | (gi < 2)) &
                            ~cfg_ff[lvocr_pkg::CFG_PD_LO + (gi % 2)];
      assign nxt_bus_data[gi*12 +: 12] = bus_word(sample_in[gi*12 +: 12], ctrl_ff, pat_ff,
                                                  user_pattern_ff, align_active, frame_strobe,
                                                  lfsr_ff[11:0]);
      assign nxt_stb[gi] = frame_strobe ^ (ctrl_ff[lvocr_pkg::CTRL_SCR] & lfsr_ff[14]);
    end
  endgenerate

  // registered lvds outputs with gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_data_ff <= 48'h0000_0000_0000;
      stb_ff      <= 4'h0;
      dclk_ff     <= 4'h0;
      req_ff      <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        bus_data_ff[i*12 +: 12] <= bus_used[i] ? nxt_bus_data[i*12 +: 12] : 12'h000;
        stb_ff[i]  <= bus_used[i] & cse_ff[4+i] & nxt_stb[i];
        dclk_ff[i] <= bus_used[i] & cse_ff[i] & clk_tog_ff;
      end
      req_ff <= align_active;
    end
  end

  assign prdata               = prdata_ff;
  assign pready               = pready_ff;
  assign pslverr              = pslverr_ff;
  assign bus_data             = bus_data_ff;
  assign bus_frame_strobe     = stb_ff;
  assign bus_data_clock       = dclk_ff;
  assign align_request_active = req_ff;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_fmt_samples: assert property (
    bus_used[0] && !align_active && pat_ff[7:4] == 4'h0 && !ctrl_ff[4] |=>
    bus_data_ff[11:0] == ($past(ctrl_ff[1]) ? {~$past(sample_in[11]), $past(sample_in[10:0])}
                                            : $past(sample_in[11:0])))
    else $error("sample format wrong on bus a");
  chk_user_active: assert property (
    bus_used[0] && !align_active && pat_ff[7:4] == 4'h1 && !ctrl_ff[4] |=>
    bus_data_ff[11:0] == $past(user_pattern_ff))
    else $error("active user pattern missing");
  chk_user_align: assert property (
    bus_used[0] && align_active && pat_ff[3:0] == 4'h1 && !ctrl_ff[4] |=>
    bus_data_ff[11:0] == $past(user_pattern_ff))
    else $error("alignment user pattern missing");
  chk_lsb_strobe: assert property (
    bus_used[0] && align_active && pat_ff[3:0] == 4'h2 && !ctrl_ff[4] |=>
    bus_data_ff[0] == $past(frame_strobe))
    else $error("strobe not on sample lsb");
  chk_all_strobe: assert property (
    bus_used[0] && cse_ff[4] && align_active && pat_ff[3:0] == 4'h3 && !ctrl_ff[4] |=>
    bus_data_ff[11:0] == {12{$past(frame_strobe)}} && stb_ff[0] == $past(frame_strobe))
    else $error("strobe not on all lanes");
  chk_scramble_data: assert property (
    bus_used[0] && ctrl_ff[4] && align_active && pat_ff[3:0] == 4'h3 |=>
    bus_data_ff[11:0] == ({12{$past(frame_strobe)}} ^ $past(lfsr_ff[11:0])))
    else $error("scrambled data wrong");
  chk_clock_gate: assert property (
    !cse_ff[1] || !bus_used[1] |=> !dclk_ff[1] ##1 !dclk_ff[1] || !$past(cse_ff[1], 1) == 1'b0)
    else $error("gated clock still toggles");
  chk_lane_gate: assert property (
    iface_en && !cfg_ff[1] |=> bus_data_ff[47:24] == 24'h0 && dclk_ff[3:2] == 2'h0)
    else $error("unused buses active in two-bus mode");
  chk_pd_gate: assert property (
    cfg_ff[3] |=> bus_data_ff[23:12] == 12'h0 && stb_ff[1] == 1'b0)
    else $error("powered-down channel still drives");
  chk_disable_quiet: assert property (
    !iface_en [*2] |=> bus_data_ff == 48'h0 && dclk_ff == 4'h0 && stb_ff == 4'h0)
    else $error("disabled interface still drives");
  chk_status_level: assert property (
    access && !pwrite && idx == lvocr_pkg::IDX_STATUS && paddr[1:0] == 2'h0 |=>
    pready_ff && prdata_ff[5] == $past(sel_n))
    else $error("status level bit wrong");
  chk_src_none: assert property (
    src == lvocr_pkg::SRC_NONE && cfg_ff[5] |-> !align_active ##1 !req_ff)
    else $error("request pins not ignored");
  chk_src_pin: assert property (
    src == lvocr_pkg::SRC_PIN && !sync_ff[0] |=> req_ff)
    else $error("pin request not taken");
  chk_src_timestamp: assert property (
    src == lvocr_pkg::SRC_TS && cfg_ff[4] && !sync_ff[1] |=> req_ff)
    else $error("timestamp request not taken");
  chk_sw_request: assert property (
    !cfg_ff[5] |=> req_ff)
    else $error("software request ignored");
  chk_realign_set: assert property (
    clock_realign_event |=> realigned_ff && alarm_ff)
    else $error("realign flag not set");
  chk_realign_clear: assert property (
    wr_ok && pstrb[0] && idx == lvocr_pkg::IDX_STATUS && pwdata[4] && !clock_realign_event
    |=> !realigned_ff && alarm_ff == $past(alarm_ff))
    else $error("realign clear wrong");
  chk_aligned_set: assert property (
    sref_rise && iface_en |=> aligned_ff)
    else $error("aligned flag not set");
  chk_aligned_clear: assert property (
    wr_ok && pstrb[0] && idx == lvocr_pkg::IDX_STATUS && pwdata[3] && !(sref_rise && iface_en)
    |=> !aligned_ff)
    else $error("aligned flag not cleared");

  cov_align_all: cover property (bus_used[0] && align_active && pat_ff[3:0] == 4'h3);
  cov_scramble: cover property (bus_used[3] && ctrl_ff[4]);
  cov_status_read: cover property (access && !pwrite && idx == lvocr_pkg::IDX_STATUS);
  cov_sref_edge: cover property (sref_rise && iface_en ##1 aligned_ff);

endmodule // lvocr_regs

/* File: test/lvocr_rx_model.sv */
// receiver-side model: request pins, reference clock, data clock watcher
module lvocr_rx_model (
  pclk,
  want_pin,
  want_ts,
  sref_run,
  bus_data_clock,
  align_request_pin,
  timestamp_input_pair,
  system_reference,
  clk_edges
);
  timeunit 1ns;
  timeprecision 1ps;
  input  wire logic        pclk;
  input  wire logic        want_pin;
  input  wire logic        want_ts;
  input  wire logic        sref_run;
  input  wire logic [3:0]  bus_data_clock;
  output logic             align_request_pin;
  output logic             timestamp_input_pair;
  output logic             system_reference;
  output int               clk_edges;
  logic [3:0] last_clk_ff;
  // active-low requests from the receiver
  assign align_request_pin    = ~want_pin;
  assign timestamp_input_pair = ~want_ts;
  // reference clock, 800 ns period, still when not running
  initial begin
    system_reference = 1'b0;
    #13;
    forever begin
      #400;
      system_reference = sref_run ? ~system_reference : 1'b0;
    end
  end
  // counts pclk cycles in which the receiver sees any data clock change, starts at zero
  always @(posedge pclk) begin
    if (bus_data_clock !== last_clk_ff) begin
      clk_edges = clk_edges + 1;
    end
    last_clk_ff <= bus_data_clock;
  end
endmodule // lvocr_rx_model

/* File: test/lvds_output_control_regs_test.sv */
// self-checking bench for the lvds output control registers
module lvds_output_control_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_n, ts_n, sref, realign = 1'b0, fstrobe = 1'b1;
  logic        want_pin = 1'b0, want_ts = 1'b0, sref_run = 1'b0;
  logic [47:0] samples = 48'h2468ac02468a;
  logic [47:0] bus_data;
  logic [3:0]  bus_strobe, bus_clk;
  logic        req_active;
  int          clk_edges, fail_count = 0, check_count = 0;
  // clock, 100 ns period
  always #50 pclk = ~pclk;
  lvocr_regs dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .align_request_pin(pin_n),
    .timestamp_input_pair(ts_n), .system_reference(sref), .clock_realign_event(realign),
    .frame_strobe(fstrobe), .sample_in(samples), .bus_data(bus_data),
    .bus_frame_strobe(bus_strobe), .bus_data_clock(bus_clk),
    .align_request_active(req_active));
  lvocr_rx_model rx_u (.pclk(pclk), .want_pin(want_pin), .want_ts(want_ts),
    .sref_run(sref_run), .bus_data_clock(bus_clk), .align_request_pin(pin_n),
    .timestamp_input_pair(ts_n), .system_reference(sref), .clk_edges(clk_edges));
  // comparison with counting
  task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic is_wr, input logic [9:0] idx, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= is_wr;
    pwdata  <= d;
    paddr   <= {idx, 2'b00};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask
  task automatic rd(input string nm, input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
    check(nm, {16'h0, r}, {16'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // clocks in tog toggle, all others stay low
  task automatic clk_chk(input logic [3:0] tog);
    logic [3:0] c0;
    int         n0;
    @(negedge pclk);
    c0 = bus_clk;
    n0 = clk_edges;
    @(negedge pclk);
    check("clk toggle", {44'h0, c0 ^ bus_clk}, {44'h0, tog});
    check("clk idle", {44'h0, bus_clk & ~tog}, 48'h0);
    check("rx clk edges", 48'(clk_edges - n0), {47'h0, tog != 4'h0});
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog
  initial begin
    #300000;
    fail_count++;
    end_sim();
  end
  // main sequence
  initial begin
    logic [31:0] r;
    logic e;
    cyc(2);
    presetn <= 1'b1;
    rd("ctrl rst", lvocr_pkg::IDX_CTRL, 32'h02);
    rd("pat rst", lvocr_pkg::IDX_PAT, 32'h02);
    rd("cse rst", lvocr_pkg::IDX_CSE, 32'hff);
    rd("cfg rst", lvocr_pkg::IDX_CFG, 32'h22);
    apb(1'b0, 10'h240, 32'h0, r, e);
    check("unmapped err", {47'h0, e}, 48'h1);
    wr(lvocr_pkg::IDX_CFG, 32'h23);
    cyc(6);
    check("twos compl", bus_data, 48'ha460ac824e8a);
    check("strobes", {44'h0, bus_strobe}, 48'hf);
    clk_chk(4'hf);
    sref_run <= 1'b1;
    cyc(12);
    sref_run <= 1'b0;
    rd("aligned set", lvocr_pkg::IDX_STATUS, 32'h28);
    wr(lvocr_pkg::IDX_STATUS, 32'h08);
    rd("aligned clr", lvocr_pkg::IDX_STATUS, 32'h20);
    realign <= 1'b1;
    @(posedge pclk) realign <= 1'b0;
    rd("realigned set", lvocr_pkg::IDX_STATUS, 32'h30);
    wr(lvocr_pkg::IDX_STATUS, 32'h10);
    rd("realigned clr", lvocr_pkg::IDX_STATUS, 32'h20);
    rd("alarm kept", lvocr_pkg::IDX_CFG, 32'h123);
    want_pin <= 1'b1;
    cyc(6);
    check("pin request", {47'h0, req_active}, 48'h1);
    check("strobe on lsb", bus_data, 48'ha470ad825e8b);
    rd("level low", lvocr_pkg::IDX_STATUS, 32'h00);
    wr(lvocr_pkg::IDX_CFG, 32'h22);
    cyc(4);
    check("off data", bus_data, 48'h0);
    clk_chk(4'h0);
    // reconfigure only while disabled
    wr(lvocr_pkg::IDX_CTRL, 32'h08);
    wr(lvocr_pkg::IDX_PAT, 32'h13);
    wr(lvocr_pkg::IDX_USER_PATTERN, 32'habc);
    wr(lvocr_pkg::IDX_CSE, 32'h5a);
    wr(lvocr_pkg::IDX_CFG, 32'h23);
    cyc(6);
    check("pins ignored", {47'h0, req_active}, 48'h0);
    rd("level none", lvocr_pkg::IDX_STATUS, 32'h20);
    check("user pattern", bus_data, {4{12'habc}});
    check("strobe gate", {44'h0, bus_strobe}, 48'h5);
    clk_chk(4'ha);
    wr(lvocr_pkg::IDX_CFG, 32'h03);
    cyc(4);
    check("sw request", {47'h0, req_active}, 48'h1);
    check("strobe all", bus_data, 48'hffffffffffff);
    // a low frame strobe must show as low on every lane and strobe
    fstrobe <= 1'b0;
    cyc(3);
    check("strobe all low", bus_data, 48'h0);
    check("strobe pins low", {44'h0, bus_strobe}, 48'h0);
    fstrobe <= 1'b1;
    want_pin <= 1'b0;
    wr(lvocr_pkg::IDX_CFG, 32'h22);
    wr(lvocr_pkg::IDX_CTRL, 32'h04);
    wr(lvocr_pkg::IDX_CFG, 32'h33);
    want_ts <= 1'b1;
    cyc(6);
    check("ts request", {47'h0, req_active}, 48'h1);
    want_ts <= 1'b0;
    wr(lvocr_pkg::IDX_CFG, 32'h22);
    wr(lvocr_pkg::IDX_CSE, 32'hff);
    wr(lvocr_pkg::IDX_CFG, 32'h21);
    cyc(6);
    check("two buses", bus_data, {24'h0, 24'habcabc});
    check("two strobes", {44'h0, bus_strobe}, 48'h3);
    clk_chk(4'h3);
    wr(lvocr_pkg::IDX_CFG, 32'h27);
    cyc(6);
    check("pd channel", bus_data, 48'habc000abc000);
    check("pd strobes", {44'h0, bus_strobe}, 48'ha);
    // offset binary samples, then user pattern while aligning
    wr(lvocr_pkg::IDX_CFG, 32'h22);
    wr(lvocr_pkg::IDX_CTRL, 32'h00);
    wr(lvocr_pkg::IDX_PAT, 32'h01);
    wr(lvocr_pkg::IDX_CFG, 32'h23);
    cyc(6);
    check("offset binary", bus_data, 48'h2468ac02468a);
    want_pin <= 1'b1;
    cyc(6);
    check("align user", bus_data, {4{12'habc}});
    want_pin <= 1'b0;
    wr(lvocr_pkg::IDX_CFG, 32'h22);
    wr(lvocr_pkg::IDX_CTRL, 32'h10);
    wr(lvocr_pkg::IDX_PAT, 32'h13);
    wr(lvocr_pkg::IDX_CFG, 32'h23);
    cyc(6);
    check("scrambled", {47'h0, bus_data === {4{12'habc}}}, 48'h0);
    want_pin <= 1'b1;
    cyc(4);
    check("scrambled align", {47'h0, bus_data === 48'hffffffffffff}, 48'h0);
    end_sim();
  end
endmodule // lvds_output_control_regs_test
